// *** logic/keypad_pkg.sv ***
// Purpose: Shared constants and types for the keypad interrupt unit
// Assumes: APB slave with 32-bit data, one register per aligned word
// Notes:   Printed offsets are not multiples of four, so they are indices
package keypad_pkg;

  localparam int          KEY_COUNT       = 8;
  localparam int          SYNC_STAGES     = 2;
  // Register indices; the byte address is four times the index
  localparam logic [7:0]  STATUS_CTRL_IDX = 8'h1a;
  localparam logic [7:0]  PIN_ENABLE_IDX  = 8'h1b;
  localparam logic [11:0] STATUS_CTRL_ADR = {2'h0, STATUS_CTRL_IDX, 2'h0};
  localparam logic [11:0] PIN_ENABLE_ADR  = {2'h0, PIN_ENABLE_IDX, 2'h0};
  // Status/control field positions
  localparam int          MODE_BIT        = 0;
  localparam int          MASK_BIT        = 1;
  localparam int          ACK_BIT         = 2;
  localparam int          FLAG_BIT        = 3;
  // Reset values
  localparam logic [7:0]  STATUS_CTRL_RST = 8'h00;
  localparam logic [7:0]  PIN_ENABLE_RST  = 8'h00;
  // Vector address pair this unit answers to
  localparam logic [15:0] VECTOR_HI_ADR   = 16'hffe0;
  localparam logic [15:0] VECTOR_LO_ADR   = 16'hffe1;

  typedef struct packed {
    logic [KEY_COUNT-1:0] sync1;
    logic [KEY_COUNT-1:0] sync2;
    logic                 all_high;
    logic                 pending;
    logic                 ack_seen;
    logic                 mask;
    logic                 level_mode;
    logic [KEY_COUNT-1:0] pin_enable;
    logic [31:0]          prdata;
    logic                 pslverr;
  } unit_state_s;

endpackage : keypad_pkg

// *** logic/keypad_interrupt_unit.sv ***
// Purpose: Eight-input keypad interrupt unit with one shared request
// Assumes: Key pins asynchronous; CPU flags vector fetches and break state
// Notes:   Function
// Function
// - Eight key inputs, each enabled as a source on its own
// - A set pin enable also turns on that pin's pull-up
// - Latch request when enabled keys go low after all were high
// - Edge mode ignores a fall while another enabled key is low
// - Level mode holds request until acknowledged and all keys high
// - Edge mode acknowledge clears the request immediately
// - Fetch of this unit's vector acts as acknowledge
// - Writing 1 to acknowledge bit acknowledges; it reads as 0
// - Acknowledge leaves edge detection alone; later falls latch again
// - Unmasked request goes to CPU, vector at ffe0 and ffe1
// - Reset clears request and level-sense select
// - Pending flag at bit 3, independent of mask, reset clears
// - Mask bit 1 blocks the request; reset clears it
// - Level-sense select 1 means edges plus levels, 0 edges only
// - Eight pin enable bits gate inputs; reset clears them
// - Enabled pin forced input; read needs direction bit 0
// - Keeps working in wait and stop; unmasked request wakes
// - In break, written acknowledges ignored unless break clear enable set; vector fetch still acknowledges
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps

module keypad_interrupt_unit
  import keypad_pkg::*;
#(
  parameter int N_KEYS = KEY_COUNT
)(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              srst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // Key pins and port control
  input  wire logic [N_KEYS-1:0] key_inputs,
  input  wire logic [N_KEYS-1:0] port_dir_out,
  output logic [N_KEYS-1:0]      pullup_enable,
  output logic [N_KEYS-1:0]      port_force_input,
  output logic [N_KEYS-1:0]      pin_read_allowed,
  // CPU side
  input  wire logic              vector_fetch,
  input  wire logic [15:0]       fetch_addr,
  input  wire logic              break_state,
  input  wire logic              break_clear_enable,
  output logic                   cpu_irq,
  output logic                   wake_request,
  output logic                   pending_flag
);

  unit_state_s st;
  unit_state_s next_st;

  logic [N_KEYS-1:0] en_low;
  logic              any_low;
  logic              wr_sc;
  logic              wr_en;
  logic              sw_ack;
  logic              fetch_ack;
  logic              ack;
  logic              fall;

  always_comb
  begin
    en_low   = st.pin_enable & ~st.sync2;
    any_low  = |en_low;
    wr_sc    = psel && penable && pwrite && paddr == STATUS_CTRL_ADR;
    wr_en    = psel && penable && pwrite && paddr == PIN_ENABLE_ADR;
    sw_ack   = wr_sc && pwdata[ACK_BIT]
               && (!break_state || break_clear_enable);
    fetch_ack = vector_fetch
                && (fetch_addr == VECTOR_HI_ADR
                    || fetch_addr == VECTOR_LO_ADR);
    ack      = sw_ack || fetch_ack;
    // Only a first key down after all high
    fall     = any_low && st.all_high;
  end

  always_comb
  begin
    next_st = st;
    next_st.sync1    = key_inputs;
    next_st.sync2    = st.sync1;
    next_st.all_high = !any_low;
    next_st.prdata   = 32'h0;
    next_st.pslverr  = 1'b0;
    if (wr_sc)
    begin
      next_st.level_mode = pwdata[MODE_BIT];
      next_st.mask       = pwdata[MASK_BIT];
    end
    if (wr_en)
      next_st.pin_enable = pwdata[N_KEYS-1:0];
    // Latch update; a new edge wins over acknowledge
    if (!st.level_mode)
    begin
      next_st.ack_seen = 1'b0;
      if (fall)
        next_st.pending = 1'b1;
      else if (ack)
        next_st.pending = 1'b0;
    end
    else
    begin
      if (fall)
      begin
        next_st.pending  = 1'b1;
        next_st.ack_seen = 1'b0;
      end
      else if (st.pending)
      begin
        if ((ack || st.ack_seen) && !any_low)
        begin
          next_st.pending  = 1'b0;
          next_st.ack_seen = 1'b0;
        end
        else if (ack)
          next_st.ack_seen = 1'b1;
      end
    end
    // APB read data, registered during the setup cycle
    if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        STATUS_CTRL_ADR:
        begin
          next_st.prdata[FLAG_BIT] = st.pending;
          next_st.prdata[MASK_BIT] = st.mask;
          next_st.prdata[MODE_BIT] = st.level_mode;
        end
        PIN_ENABLE_ADR:
          next_st.prdata[N_KEYS-1:0] = st.pin_enable;
        default:
          next_st.pslverr = 1'b1;
      endcase
    end
    if (psel && !penable && pwrite
        && paddr != STATUS_CTRL_ADR && paddr != PIN_ENABLE_ADR)
      next_st.pslverr = 1'b1;
  end

  // Synchronous reset clears latch, mode, mask, enables
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      st            <= '0;
      st.mask       <= STATUS_CTRL_RST[MASK_BIT];
      st.level_mode <= STATUS_CTRL_RST[MODE_BIT];
      st.pin_enable <= PIN_ENABLE_RST;
    end
    else
      st <= next_st;
  end

  assign pready  = 1'b1;
  assign prdata  = st.prdata;
  assign pslverr = st.pslverr;
  assign pullup_enable    = st.pin_enable;
  assign port_force_input = st.pin_enable;
  assign pin_read_allowed = ~port_dir_out;
  // Masked request out, also the wake source
  assign cpu_irq      = st.pending && !st.mask;
  assign wake_request = st.pending && !st.mask;
  assign pending_flag = st.pending;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  mask_blocks_a: assert property (st.mask |-> !cpu_irq)
    else $error("masked request reached cpu");
  irq_follows_a: assert property (pending_flag && !st.mask |-> cpu_irq)
    else $error("unmasked request not presented");
  edge_latch_a: assert property (fall |=> pending_flag)
    else $error("falling key did not latch");
  no_edge_a: assert property (!st.all_high && !st.level_mode
      && !pending_flag |=> !pending_flag)
    else $error("edge latched while key low");
  edge_ack_a: assert property (!st.level_mode && ack && !fall
      |=> !pending_flag)
    else $error("edge mode ack did not clear");
  level_hold_a: assert property (st.level_mode && pending_flag && any_low
      && !wr_sc |=> pending_flag)
    else $error("level request dropped while low");
  break_block_a: assert property (break_state && !break_clear_enable
      && !fetch_ack && !st.ack_seen && pending_flag && !fall
      |=> pending_flag)
    else $error("ack acted during protected break");
  pullup_a: assert property (pullup_enable == st.pin_enable)
    else $error("pull-up not following enable");
  read_zero_a: assert property (psel && !penable && !pwrite
      && paddr == STATUS_CTRL_ADR |=> prdata[7:4] == 4'h0
      && !prdata[ACK_BIT])
    else $error("status read shows stray bits");
  reset_clear_a: assert property (@(posedge core_clk) disable iff (1'b0)
      srst |=> !pending_flag && !st.level_mode && !st.mask)
    else $error("reset did not clear state");

  edge_hit_c:  cover property (!st.level_mode && fall ##1 pending_flag);
  level_hit_c: cover property (st.level_mode && pending_flag && ack
      && any_low);
  fetch_c:     cover property (fetch_ack && pending_flag);
  break_c:     cover property (break_state && sw_ack);

endmodule : keypad_interrupt_unit

// *** tb/key_switch_model.sv ***
// Purpose: Key switches with pull-ups and a CPU that fetches vectors
// Assumes: Released enabled pins rise through the pull-up at once
// Notes:   Pins neither pulled up nor outputs toggle so stale levels never look valid
`timescale 1ns/1ps
module key_switch_model (
  // Clock
  input  wire logic        core_clk,
  // Bench commands
  input  wire logic [7:0]  press,
  input  wire logic        fetch_go,
  // Unit side
  input  wire logic [7:0]  pullup_enable,
  input  wire logic [7:0]  port_dir_out,
  input  wire logic        cpu_irq,
  output logic [7:0]       key_inputs,
  output logic             vector_fetch = 1'b0,
  output logic [15:0]      fetch_addr = 16'h0f0f
);
  logic [7:0] tog = 8'h55;
  logic [7:0] held;
  // Pins driven high as outputs, or pulled up, idle high
  assign held       = pullup_enable | port_dir_out;
  assign key_inputs = (held & ~press) | (~held & tog);
  // CPU fetches only a presented request
  always @(posedge core_clk)
  begin
    tog          <= ~tog;
    vector_fetch <= fetch_go & cpu_irq;
    fetch_addr   <= (fetch_go & cpu_irq) ? 16'hffe0 : fetch_addr ^ 16'h00f0;
  end
endmodule : key_switch_model

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench for the keypad interrupt unit
// Assumes: Key changes reach the flag within four edges
// Notes:   Init follows mask, enable, acknowledge, unmask
`timescale 1ns/1ps
module tb_top;
  import keypad_pkg::*;
  logic core_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic fetch_go = 0, break_state = 0, break_clear_enable = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [7:0]  press = '0, port_dir_out = 8'h0f, key_inputs;
  logic [7:0]  pullup_enable, port_force_input, pin_read_allowed;
  logic        pready, pslverr, er, vector_fetch;
  logic        cpu_irq, wake_request, pending_flag;
  logic [15:0] fetch_addr;
  int          n_errors = 0, n_checks = 0, cyc = 0;
  keypad_interrupt_unit keypad_interrupt_unit_inst (.core_clk, .srst,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .key_inputs, .port_dir_out, .pullup_enable,
    .port_force_input, .pin_read_allowed, .vector_fetch, .fetch_addr,
    .break_state, .break_clear_enable, .cpu_irq, .wake_request,
    .pending_flag);
  key_switch_model key_switch_model_inst (.core_clk, .press, .fetch_go,
    .pullup_enable, .port_dir_out, .cpu_irq, .key_inputs, .vector_fetch,
    .fetch_addr);
  initial forever #50 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc   <= cyc + 1;
    if (cyc == 3000)
    begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wt
  task automatic apb(input logic w, input logic [11:0] a, input int d);
    @(posedge core_clk);
    psel   <= 1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    // Outputs read here still hold the pre-edge values
    do @(posedge core_clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 0;
    penable <= 0;
  endtask : apb
  task automatic init(input logic m);
    apb(1, STATUS_CTRL_ADR, 2 | m);
    apb(1, PIN_ENABLE_ADR, 8'hff);
    // Pull-up settling before the acknowledge
    wt(4);
    apb(1, STATUS_CTRL_ADR, 6 | m);
    apb(1, STATUS_CTRL_ADR, m);
    chk(pending_flag, 0);
  endtask : init
  task automatic t_regs();
    apb(0, STATUS_CTRL_ADR, 0);
    chk(rd, STATUS_CTRL_RST);
    apb(0, PIN_ENABLE_ADR, 0);
    chk(rd, PIN_ENABLE_RST);
    // Output pins already high, so enabling them latches nothing
    apb(1, PIN_ENABLE_ADR, 8'h0f);
    wt(4);
    chk(pending_flag, 0);
    apb(1, PIN_ENABLE_ADR, 8'ha5);
    apb(0, PIN_ENABLE_ADR, 0);
    chk(rd, 8'ha5);
    chk({pullup_enable, port_force_input}, 16'ha5a5);
    chk(pin_read_allowed, 8'hf0);
    apb(1, STATUS_CTRL_ADR, 7);
    apb(0, STATUS_CTRL_ADR, 0);
    chk(rd, 3);
    apb(0, 12'h070, 0);
    chk(er, 1);
    chk(rd, 0);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_edge();
    init(0);
    press <= 8'h01;
    wt(4);
    chk({cpu_irq, wake_request, pending_flag}, 7);
    apb(0, STATUS_CTRL_ADR, 0);
    chk(rd, 8'h08);
    apb(1, STATUS_CTRL_ADR, 4);
    wt(1);
    chk(pending_flag, 0);
    press <= 8'h03;
    wt(4);
    chk(pending_flag, 0);
    press <= 0;
    wt(4);
    press <= 8'h04;
    wt(4);
    chk(pending_flag, 1);
    fetch_go <= 1;
    wt(3);
    fetch_go <= 0;
    chk(pending_flag, 0);
    press <= 0;
    $display("t_edge done");
  endtask : t_edge
  task automatic t_level();
    init(1);
    press <= 8'h80;
    wt(4);
    apb(1, STATUS_CTRL_ADR, 5);
    wt(2);
    chk(pending_flag, 1);
    apb(1, STATUS_CTRL_ADR, 3);
    wt(1);
    chk({cpu_irq, wake_request, pending_flag}, 1);
    press <= 0;
    wt(4);
    chk(pending_flag, 0);
    apb(1, STATUS_CTRL_ADR, 1);
    press <= 8'h80;
    wt(4);
    srst <= 1;
    wt(2);
    srst <= 0;
    wt(1);
    chk(pending_flag, 0);
    apb(0, STATUS_CTRL_ADR, 0);
    chk(rd, 0);
    press <= 0;
    $display("t_level done");
  endtask : t_level
  task automatic t_break();
    init(0);
    press <= 8'h10;
    wt(4);
    break_state <= 1;
    apb(1, STATUS_CTRL_ADR, 4);
    wt(1);
    chk(pending_flag, 1);
    break_clear_enable <= 1;
    apb(1, STATUS_CTRL_ADR, 4);
    break_state <= 0;
    wt(2);
    chk(pending_flag, 0);
    $display("t_break done");
  endtask : t_break
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  initial
  begin
    wt(5);
    srst <= 0;
    t_regs();
    t_edge();
    t_level();
    t_break();
    wrap_up();
  end
endmodule : tb_top
